/* File: radio_power_mode_control_bench.sv */
`timescale 1ns/1ns
`include "rpm_defs.svh"
module radio_power_mode_control_bench;
  logic        clk, nrst, hsel, hwrite, hreadyout, hresp, brownout_in;
  logic        fill, drain_on, wake_req, sel_n, fifo_empty, awake;
  logic        miso, miso_oe, xtal_en, ref_en, synth_en, synth_tx;
  logic        rx_en, tx_en, core_supply_en, wake_osc_en, wake_clk;
  logic        fifo_access, fifo_clear, xcvr_reset, irq, wk_q, init_low;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r, d;
  logic [8:0]  outs;
  logic [3:0]  m;
  int          failures, n_checks, cyc, n_clr, tog, i;
  logic [3:0]  codes [7] = '{4'h0, 4'h5, 4'h6, 4'h8, 4'h9, 4'hb, 4'hc};

  assign outs = {xtal_en, ref_en, synth_en, synth_tx, rx_en, tx_en,
                 core_supply_en, wake_osc_en, fifo_access};

  rpm_power_ctrl #(.INIT_CYC(4), .SETTLE_CYC(4), .WAKE_DIV(4)) dut_u (
    .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sel_n(sel_n),
    .brownout_in(brownout_in), .fifo_empty(fifo_empty), .miso(miso),
    .miso_oe(miso_oe), .xtal_en(xtal_en), .ref_en(ref_en),
    .synth_en(synth_en), .synth_tx(synth_tx), .rx_en(rx_en),
    .tx_en(tx_en), .core_supply_en(core_supply_en),
    .wake_osc_en(wake_osc_en), .wake_clk(wake_clk),
    .fifo_access(fifo_access), .fifo_clear(fifo_clear),
    .xcvr_reset(xcvr_reset), .irq(irq));

  rpm_host_model host_u (
    .clk(clk), .nrst(nrst), .fill(fill), .drain_on(drain_on),
    .wake_req(wake_req), .miso(miso), .miso_oe(miso_oe),
    .fifo_clear(fifo_clear), .sel_n(sel_n), .fifo_empty(fifo_empty),
    .awake(awake));

  // ----------------------------------------
  // Clock, monitors, hang guard
  // ----------------------------------------
  initial clk = 1'b0;
  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (fifo_clear === 1'b1) n_clr = n_clr + 1;
    if (wake_clk !== wk_q) tog = tog + 1;
    wk_q = wake_clk;
    if (xcvr_reset === 1'b1 && miso_oe === 1'b1 && miso === 1'b0)
      init_low = 1'b1;
    if (cyc == 20000) begin
      failures = failures + 1;
      conclude();
    end
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks = n_checks + 1;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      failures = failures + 1;
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Mask and expected value of outs for each mode
  function automatic logic [17:0] exp_of(input logic [3:0] c);
    case (c)
      4'h0: return {9'h1ff, 9'h000};
      4'hb: return {9'h1ff, 9'h002};
      4'h5: return {9'h199, 9'h180};
      4'h6: return {9'h081, 9'h081};
      4'h8: return {9'h07c, 9'h044};
      4'h9: return {9'h054, 9'h054};
      4'hc: return {9'h07c, 9'h064};
      default: return {9'h04c, 9'h04c};
    endcase
  endfunction

  task automatic go_mode(input logic [3:0] c);
    logic [17:0] e;
    int          n;
    e = exp_of(c);
    xfer(1'b1, `RPM_OFS_MODE, {28'h0, c});
    n = 0;
    do begin
      xfer(1'b0, `RPM_OFS_STAT, 32'h0);
      n = n + 1;
    end while (r[7] !== 1'b0 && n < 100);
    chk(r & 32'h4f, {25'h0, 3'h4, c});
    if (c[3]) chk({31'h0, r[4]}, 32'h1);
    chk({23'h0, outs & e[17:9]}, {23'h0, e[8:0]});
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {nrst, hsel, hwrite, brownout_in, fill, drain_on, wake_req} = '0;
    {htrans, haddr, hwdata} = '0;
    {failures, n_checks, cyc, n_clr, tog} = '0;
    wk_q = 1'b0;
    init_low = 1'b0;
    d = $urandom(76564);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    xfer(1'b0, `RPM_OFS_MODE, 32'h0);
    chk(r, 32'h0);
    chk({23'h0, outs}, 32'h0);
    xfer(1'b0, 12'h020, 32'h0);
    chk(r, 32'h0);
    fill <= 1'b1;
    @(posedge clk);
    fill <= 1'b0;
    go_mode(4'h6);
    chk(n_clr, 0);
    xfer(1'b1, `RPM_OFS_MODE, 32'h5);
    repeat (8) @(posedge clk);
    xfer(1'b0, `RPM_OFS_STAT, 32'h0);
    chk({31'h0, r[7]}, 32'h1);
    chk(n_clr, 0);
    drain_on <= 1'b1;
    go_mode(4'h5);
    chk(n_clr, 1);
    xfer(1'b1, `RPM_OFS_MASK, 32'h0);
    xfer(1'b1, `RPM_OFS_IRQ, 32'h7);
    go_mode(4'h8);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `RPM_OFS_MASK, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, `RPM_OFS_IRQ, 32'h1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    brownout_in <= 1'b1;
    repeat (6) @(posedge clk);
    xfer(1'b0, `RPM_OFS_STAT, 32'h0);
    chk({31'h0, r[5]}, 32'h1);
    xfer(1'b1, `RPM_OFS_MASK, 32'h2);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, `RPM_OFS_IRQ, 32'h2);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    brownout_in <= 1'b0;
    repeat (6) @(posedge clk);
    xfer(1'b0, `RPM_OFS_STAT, 32'h0);
    chk({31'h0, r[5]}, 32'h0);
    go_mode(4'hb);
    tog = 0;
    repeat (40) @(posedge clk);
    chk({31'h0, tog >= 9 && tog <= 11}, 32'h1);
    go_mode(4'h0);
    tog = 0;
    repeat (40) @(posedge clk);
    chk(tog, 0);
    // Typical receive session, crystal settling scaled down
    go_mode(4'h5);
    repeat (30) @(posedge clk);
    go_mode(4'h9);
    go_mode(4'h0);
    for (i = 0; i < 12; i++) begin
      m = codes[$urandom_range(0, 6)];
      go_mode(m);
      // Transmit only after the settle mode, as a real host must
      if (m == 4'hc) go_mode(4'hd);
      d = $urandom;
      xfer(1'b1, `RPM_OFS_MASK, d);
      xfer(1'b0, `RPM_OFS_MASK, 32'h0);
      chk(r & 32'h7, d & 32'h7);
    end
    xfer(1'b1, `RPM_OFS_MASK, 32'h5);
    go_mode(4'h0);
    xfer(1'b0, `RPM_OFS_MASK, 32'h0);
    chk(r & 32'h7, 32'h5);
    xfer(1'b1, `RPM_OFS_MODE, 32'h1);
    repeat (10) @(posedge clk);
    xfer(1'b0, `RPM_OFS_MODE, 32'h0);
    chk(r, 32'h0);
    chk({23'h0, outs}, 32'h0);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    i = 0;
    while (awake !== 1'b1 && i < 300) begin
      @(posedge clk);
      i = i + 1;
    end
    chk({31'h0, awake}, 32'h1);
    chk({31'h0, init_low}, 32'h1);
    xfer(1'b0, `RPM_OFS_MASK, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, `RPM_OFS_STAT, 32'h0);
    chk(r & 32'h4f, 32'h40);
    conclude();
  end
endmodule

/* File: rpm_defs.svh */
`ifndef RPM_DEFS_SVH
`define RPM_DEFS_SVH

// Register byte offsets
`define RPM_OFS_MODE    12'h000
`define RPM_OFS_STAT    12'h004
`define RPM_OFS_IRQ     12'h008
`define RPM_OFS_MASK    12'h00c
`define RPM_OFS_ENABLES 12'h010

// Mode codes
`define RPM_MODE_RETAIN   4'h0
`define RPM_MODE_DEEP     4'h1
`define RPM_MODE_STANDBY  4'h5
`define RPM_MODE_FIFO     4'h6
`define RPM_MODE_SYN_RX   4'h8
`define RPM_MODE_RX       4'h9
`define RPM_MODE_WAKE     4'hb
`define RPM_MODE_SYN_TX   4'hc
`define RPM_MODE_TX       4'hd

`define RPM_MODE_RST      4'h0

// Status register fields
`define RPM_ST_MODE_LSB   0
`define RPM_ST_REG_RDY    4
`define RPM_ST_BROWNOUT   5
`define RPM_ST_READY      6
`define RPM_ST_PEND       7

// Event bit positions
`define RPM_EV_MODE_DONE  0
`define RPM_EV_BROWNOUT   1
`define RPM_EV_WOKE       2

// Timing
`define RPM_CLK_MHZ       100
`define RPM_REG_SETTLE_US 2
`define RPM_REG_SETTLE_CYC (`RPM_REG_SETTLE_US * `RPM_CLK_MHZ)
`define RPM_INIT_US       20
`define RPM_INIT_CYC      (`RPM_INIT_US * `RPM_CLK_MHZ)
`define RPM_WAKE_HZ       640
`define RPM_WAKE_DIV      (`RPM_CLK_MHZ * 1000000 / (2 * `RPM_WAKE_HZ))

`endif

/* File: rpm_host_model.sv */
`timescale 1ns/1ns
module rpm_host_model (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic fill,
  input  wire logic drain_on,
  input  wire logic wake_req,
  input  wire logic miso,
  input  wire logic miso_oe,
  input  wire logic fifo_clear,
  output logic      sel_n,
  output logic      fifo_empty,
  output logic      awake
);
  logic [3:0] level;
  logic [1:0] pace;
  logic       miso_hi;
  // Undriven MISO counts as low, so a dead device never looks ready
  assign miso_hi = miso_oe & miso;
  assign fifo_empty = (level == 4'h0);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level <= 4'h0;
      pace <= 2'h0;
      sel_n <= 1'b1;
      awake <= 1'b0;
    end else begin
      pace <= pace + 2'h1;
      if (fifo_clear) begin
        level <= 4'h0;
      end else if (fill) begin
        level <= 4'h5;
      end else if (drain_on && pace == 2'h3 && level != 4'h0) begin
        level <= level - 4'h1;
      end
      if (wake_req) begin
        sel_n <= 1'b0;
        awake <= 1'b0;
      end else if (!sel_n && miso_hi) begin
        sel_n <= 1'b1;
        awake <= 1'b1;
      end
    end
  end
endmodule

/* File: rpm_pkg.sv */
package rpm_pkg;

  typedef enum logic [2:0] {
    RPM_RUN    = 3'b000,
    RPM_DRAIN  = 3'b001,
    RPM_SETTLE = 3'b011,
    RPM_DEEP   = 3'b010,
    RPM_INIT   = 3'b110
  } rpm_state_t;

  typedef struct packed {
    logic [3:0]  mode;
    logic [3:0]  target;
    rpm_state_t  st;
    logic [11:0] cnt;
    logic [16:0] wcnt;
    logic        wclk;
    logic [2:0]  irq_st;
    logic [2:0]  irq_mask;
    logic        irq;
    logic        ready;
    logic        reg_rdy;
    logic [7:0]  enables;
    logic        fifo_clr;
    logic        fifo_acc;
    logic        bo_q;
    logic        hsel_d;
    logic        hwrite_d;
    logic [11:0] haddr_d;
    logic [31:0] hrdata;
    logic        sel_s1;
    logic        sel_s2;
    logic        bo_s1;
    logic        bo_s2;
    logic        fe_s1;
    logic        fe_s2;
    logic        miso_oe;
    logic        xcvr_rst;
  } rpm_state_s_t;

endpackage

/* File: rpm_power_ctrl.sv */
`timescale 1ns/1ns
`include "rpm_defs.svh"
// Summary of operation
// - Retention keeps only the register file; core supplies off; registers kept.
// - Retention blocks and clears FIFO; entry completes only once FIFO empty.
// - Code 0001 turns everything off and loses all register values.
// - Select pin low leaves full-off: device starts up and resets.
// - MISO held low during wake initialization, then high when ready.
// - Code 0101: crystal and reference on, FIFO blocked, cleared, waits empty.
// - Code 0110: reference on, registers and FIFO accessible, FIFO kept.
// - Code 1000: synthesizer on receive frequency, receiver/transmitter off.
// - Code 1001: synthesizer and receiver run.
// - Code 1011: like retention but 640 Hz wake oscillator runs.
// - Code 1100: synthesizer on transmit frequency, both paths off.
// - Regulators follow the programmed mode automatically.
// - Readable bit shows regulated supplies ready.
// - Readable brown-out bit flags I/O supply below 1.3 V.
// - Mode control independent of the microcontroller power register.
module rpm_power_ctrl
  import rpm_pkg::*;
#(
  parameter int unsigned INIT_CYC   = `RPM_INIT_CYC,
  parameter int unsigned SETTLE_CYC = `RPM_REG_SETTLE_CYC,
  parameter int unsigned WAKE_DIV   = `RPM_WAKE_DIV
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sel_n,
  input  wire logic        brownout_in,
  input  wire logic        fifo_empty,
  output logic             miso,
  output logic             miso_oe,
  output logic             xtal_en,
  output logic             ref_en,
  output logic             synth_en,
  output logic             synth_tx,
  output logic             rx_en,
  output logic             tx_en,
  output logic             core_supply_en,
  output logic             wake_osc_en,
  output logic             wake_clk,
  output logic             fifo_access,
  output logic             fifo_clear,
  output logic             xcvr_reset,
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rpm_state_s_t s;
  rpm_state_s_t next_s;
  logic         wr;
  logic         rd_ok;
  logic [3:0]   wmode;
  logic [2:0]   events;

  // Enable vector per mode: xtal ref synth stx tx rx core wake
  function automatic logic [7:0] mode_enables(input logic [3:0] m);
    logic [7:0] e;
    e = 8'h00;
    unique case (m)
      `RPM_MODE_RETAIN:  e = 8'h00;
      `RPM_MODE_DEEP:    e = 8'h00;
      `RPM_MODE_STANDBY: e = 8'hc2;
      `RPM_MODE_FIFO:    e = 8'h42;
      `RPM_MODE_SYN_RX:  e = 8'he2;
      `RPM_MODE_RX:      e = 8'he6;
      `RPM_MODE_WAKE:    e = 8'h01;
      `RPM_MODE_SYN_TX:  e = 8'hf2;
      `RPM_MODE_TX:      e = 8'hfa;
      default:           e = 8'h00;
    endcase
    return e;
  endfunction

  function automatic logic fifo_open(input logic [3:0] m);
    return (m == `RPM_MODE_FIFO) || (m == `RPM_MODE_SYN_RX) ||
           (m == `RPM_MODE_RX) || (m == `RPM_MODE_SYN_TX) ||
           (m == `RPM_MODE_TX);
  endfunction

  // Modes that clear the FIFO and must see it empty first
  function automatic logic needs_drain(input logic [3:0] m);
    return (m == `RPM_MODE_RETAIN) || (m == `RPM_MODE_STANDBY) ||
           (m == `RPM_MODE_WAKE);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s   = s;
    wmode    = hwdata[3:0];
    wr       = s.hsel_d && s.hwrite_d;
    rd_ok    = 1'b1;
    events   = 3'b000;

    // Pin synchronisers
    next_s.sel_s1 = sel_n;
    next_s.sel_s2 = s.sel_s1;
    next_s.bo_s1  = brownout_in;
    next_s.bo_s2  = s.bo_s1;
    next_s.fe_s1  = fifo_empty;
    next_s.fe_s2  = s.fe_s1;
    next_s.bo_q   = s.bo_s2;

    // Address phase capture
    next_s.hsel_d   = hsel && hready && htrans[1];
    next_s.hwrite_d = hwrite;
    next_s.haddr_d  = haddr[11:0];
    next_s.fifo_clr = 1'b0;

    unique case (s.st)
      RPM_RUN: begin
        if (wr && s.haddr_d == `RPM_OFS_MODE) begin
          next_s.target = wmode;
          if (wmode == `RPM_MODE_DEEP) begin
            next_s.mode = wmode;
            next_s.st   = RPM_DEEP;
          end else if (needs_drain(wmode)) begin
            next_s.fifo_acc = 1'b0;
            next_s.st       = RPM_DRAIN;
          end else begin
            next_s.mode    = wmode;
            next_s.reg_rdy = 1'b0;
            next_s.cnt     = 12'(SETTLE_CYC);
            next_s.st      = RPM_SETTLE;
          end
        end
      end
      RPM_DRAIN: begin
        if (s.fe_s2) begin
          next_s.mode     = s.target;
          next_s.fifo_clr = 1'b1;
          next_s.reg_rdy  = 1'b0;
          next_s.cnt      = 12'(SETTLE_CYC);
          next_s.st       = RPM_SETTLE;
        end
      end
      RPM_SETTLE: begin
        if (s.cnt <= 12'd1) begin
          next_s.reg_rdy  = 1'b1;
          next_s.fifo_acc = fifo_open(s.mode);
          next_s.st       = RPM_RUN;
          events[`RPM_EV_MODE_DONE] = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 12'd1;
        end
      end
      RPM_DEEP: begin
        rd_ok = 1'b0;
        if (!s.sel_s2) begin
          next_s.cnt = 12'(INIT_CYC);
          next_s.st  = RPM_INIT;
        end
      end
      RPM_INIT: begin
        rd_ok = 1'b0;
        if (s.cnt <= 12'd1) begin
          next_s.ready   = 1'b1;
          next_s.mode    = `RPM_MODE_RST;
          next_s.reg_rdy = 1'b1;
          next_s.st      = RPM_RUN;
          events[`RPM_EV_WOKE] = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 12'd1;
        end
      end
    endcase

    events[`RPM_EV_BROWNOUT] = s.bo_s2 && !s.bo_q;

    if (wr && rd_ok && s.haddr_d == `RPM_OFS_MASK)
      next_s.irq_mask = hwdata[2:0];
    // Set beats write-one-to-clear
    if (wr && rd_ok && s.haddr_d == `RPM_OFS_IRQ)
      next_s.irq_st = (s.irq_st & ~hwdata[2:0]) | events;
    else
      next_s.irq_st = s.irq_st | events;

    // Full-off wipes registers; wake restarts from reset values.
    // Done on entry so MISO is already low in the first full-off cycle.
    if (next_s.st == RPM_DEEP) begin
      next_s.ready    = 1'b0;
      next_s.irq_st   = 3'b000;
      next_s.irq_mask = 3'b000;
      next_s.reg_rdy  = 1'b0;
      next_s.fifo_acc = 1'b0;
    end
    next_s.irq = |(next_s.irq_st & next_s.irq_mask);

    // Wake oscillator only while its mode is active
    if (next_s.mode == `RPM_MODE_WAKE && s.st == RPM_RUN) begin
      if (s.wcnt >= 17'(WAKE_DIV - 1)) begin
        next_s.wcnt = 17'd0;
        next_s.wclk = !s.wclk;
      end else begin
        next_s.wcnt = s.wcnt + 17'd1;
      end
    end else begin
      next_s.wcnt = 17'd0;
      next_s.wclk = 1'b0;
    end

    next_s.enables = mode_enables(next_s.mode);
    if (next_s.st == RPM_DEEP || next_s.st == RPM_INIT)
      next_s.enables = 8'h00;
    if (s.st == RPM_INIT)
      next_s.enables = 8'h00;
    next_s.miso_oe  = next_s.st == RPM_INIT || next_s.ready;
    next_s.xcvr_rst = next_s.st == RPM_INIT;

    // Register read data, taken from the next state so that a read
    // right behind a write already sees what that write stored
    next_s.hrdata = 32'h0;
    if (hsel && hready && htrans[1] && !hwrite && rd_ok) begin
      unique case (haddr[11:0])
        `RPM_OFS_MODE:    next_s.hrdata = {28'h0, next_s.mode};
        `RPM_OFS_STAT:    next_s.hrdata = {24'h0, next_s.st != RPM_RUN,
                          next_s.ready, s.bo_s2, next_s.reg_rdy,
                          next_s.mode};
        `RPM_OFS_IRQ:     next_s.hrdata = {29'h0, next_s.irq_st};
        `RPM_OFS_MASK:    next_s.hrdata = {29'h0, next_s.irq_mask};
        `RPM_OFS_ENABLES: next_s.hrdata = {24'h0, next_s.enables};
        default:          next_s.hrdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s       <= '0;
      s.mode  <= `RPM_MODE_RST;
      s.ready <= 1'b1;
      s.reg_rdy <= 1'b1;
      s.sel_s1 <= 1'b1;
      s.sel_s2 <= 1'b1;
      s.fe_s1 <= 1'b1;
      s.fe_s2 <= 1'b1;
      s.miso_oe <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata         = s.hrdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign miso           = s.ready;
  assign miso_oe        = s.miso_oe;
  assign xtal_en        = s.enables[7];
  assign ref_en         = s.enables[6];
  assign synth_en       = s.enables[5];
  assign synth_tx       = s.enables[4];
  assign rx_en          = s.enables[2];
  assign tx_en          = s.enables[3];
  assign core_supply_en = s.enables[1];
  assign wake_osc_en    = s.enables[0];
  assign wake_clk       = s.wclk;
  assign fifo_access    = s.fifo_acc;
  assign fifo_clear     = s.fifo_clr;
  assign xcvr_reset     = s.xcvr_rst;
  assign irq            = s.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence deep_wake_s;
    s.st == RPM_DEEP && !s.sel_s2;
  endsequence

  retain_off_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.mode == `RPM_MODE_RETAIN && s.st == RPM_RUN) |-> !core_supply_en)
    else $error("core supply on in retention");
  drain_wait_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.st == RPM_DRAIN && !s.fe_s2) |=> s.st == RPM_DRAIN && !fifo_access)
    else $error("retention entered with FIFO not empty");
  deep_off_a: assert property (@(posedge clk) disable iff (!nrst)
    s.st == RPM_DEEP |-> s.enables == 8'h00 && !miso)
    else $error("functions live in full-off");
  wake_start_a: assert property (@(posedge clk) disable iff (!nrst)
    deep_wake_s |=> xcvr_reset)
    else $error("no reset on select low");
  miso_init_a: assert property (@(posedge clk) disable iff (!nrst)
    xcvr_reset |-> !miso && miso_oe)
    else $error("MISO not low during init");
  fifo_keep_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.mode == `RPM_MODE_FIFO && s.st == RPM_RUN) |-> fifo_access && ref_en)
    else $error("FIFO mode without FIFO access");
  rx_path_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.mode == `RPM_MODE_RX && s.st == RPM_RUN) |-> rx_en && synth_en && !tx_en)
    else $error("receive mode wrong enables");
  synth_tx_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.mode == `RPM_MODE_SYN_TX && s.st == RPM_RUN) |-> synth_tx && !tx_en)
    else $error("transmit settle wrong enables");
  wake_osc_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.mode == `RPM_MODE_WAKE && s.st == RPM_RUN) |-> wake_osc_en
      && !core_supply_en)
    else $error("wake oscillator mode wrong");
  settle_rdy_a: assert property (@(posedge clk) disable iff (!nrst)
    s.st == RPM_SETTLE |-> !s.reg_rdy)
    else $error("supply ready while settling");

  sequence drain_done_s;
    s.st == RPM_DRAIN && s.fe_s2;
  endsequence

  sequence init_end_s;
    s.st == RPM_INIT && s.cnt <= 12'd1;
  endsequence

  drain_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    drain_done_s |=> fifo_clear && s.st == RPM_SETTLE)
    else $error("drain end without FIFO clear");
  retain_fifo_a: assert property (@(posedge clk) disable iff (!nrst)
    s.mode == `RPM_MODE_RETAIN |-> !fifo_access)
    else $error("FIFO open in retention");
  deep_wipe_a: assert property (@(posedge clk) disable iff (!nrst)
    s.st == RPM_DEEP |-> s.irq_st == 3'b000 && s.irq_mask == 3'b000)
    else $error("registers kept in full-off");
  read_off_a: assert property (@(posedge clk) disable iff (!nrst)
    s.st == RPM_DEEP |=> hrdata == 32'h0)
    else $error("register read in full-off");
  deep_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.st == RPM_DEEP && s.sel_s2) |=> s.st == RPM_DEEP)
    else $error("full-off left without select");
  init_off_a: assert property (@(posedge clk) disable iff (!nrst)
    xcvr_reset |-> s.enables == 8'h00)
    else $error("functions live during init");
  miso_ready_a: assert property (@(posedge clk) disable iff (!nrst)
    init_end_s |=> miso && miso_oe)
    else $error("MISO not high after init");
  standby_en_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.mode == `RPM_MODE_STANDBY && s.st == RPM_RUN) |-> xtal_en && ref_en
      && !rx_en && !tx_en && !fifo_access)
    else $error("standby mode wrong enables");
  fifo_noclr_a: assert property (@(posedge clk) disable iff (!nrst)
    s.mode == `RPM_MODE_FIFO |-> !fifo_clear)
    else $error("FIFO cleared in FIFO mode");
  synth_rx_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.mode == `RPM_MODE_SYN_RX && s.st == RPM_RUN) |-> synth_en
      && !synth_tx && !rx_en && !tx_en)
    else $error("receive settle wrong enables");
  wake_clk_a: assert property (@(posedge clk) disable iff (!nrst)
    s.mode != `RPM_MODE_WAKE |-> !wake_clk)
    else $error("wake clock outside wake mode");
  tx_path_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.mode == `RPM_MODE_TX && s.st == RPM_RUN) |-> tx_en && synth_tx
      && !rx_en)
    else $error("transmit mode wrong enables");
  ready_run_a: assert property (@(posedge clk) disable iff (!nrst)
    s.st == RPM_RUN |-> s.reg_rdy)
    else $error("supply not ready in steady mode");
  brownout_ev_a: assert property (@(posedge clk) disable iff (!nrst)
    (s.bo_s2 && !s.bo_q) |=> s.irq_st[`RPM_EV_BROWNOUT] || s.st == RPM_DEEP)
    else $error("brown-out event not flagged");

endmodule
